/* hw/mcpt_deadtime.sv */
// Complementary output pair with dead-time insertion for one PWM phase.
// Assumes the reference is produced on the same clock; force_off_i is synchronous.
`default_nettype none
module mcpt_deadtime
    import mcpt_pkg::*;
#(
    parameter int unsigned DT_W = 8
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    // Control
    input  wire logic            enable_i,
    input  wire logic            force_off_i,
    input  wire logic [DT_W-1:0] dead_time_i,
    input  wire logic            ref_i,
    // Gate outputs
    output logic                 out_hi_o,
    output logic                 out_lo_o
);
    logic [DT_W-1:0] dt_cnt_reg;
    logic            ref_d_reg;

    // Restart the dead-time count on every reference edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_d_reg  <= 1'b0;
            dt_cnt_reg <= '0;
        end else begin
            ref_d_reg <= ref_i;
            if (ref_i != ref_d_reg) begin
                dt_cnt_reg <= dead_time_i;
            end else if (dt_cnt_reg != '0) begin
                dt_cnt_reg <= dt_cnt_reg - 1'b1;
            end
        end
    end

    // Both gates low while the dead time runs, so the switches never overlap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_hi_o <= 1'b0;
            out_lo_o <= 1'b0;
        end else if (!enable_i || force_off_i) begin
            out_hi_o <= 1'b0;
            out_lo_o <= 1'b0;
        end else if ((ref_i != ref_d_reg && dead_time_i != '0) || dt_cnt_reg > 1) begin
            out_hi_o <= 1'b0;
            out_lo_o <= 1'b0;
        end else begin
            out_hi_o <= ref_d_reg;
            out_lo_o <= ~ref_d_reg;
        end
    end
endmodule : mcpt_deadtime
`default_nettype wire

/* hw/mcpt_pkg.sv */
// Package for the motor control PWM timer: modes, directions and reset values.
// Assumes a single timer kernel clock domain.
`default_nettype none
package mcpt_pkg;
    localparam int unsigned MCPT_CNT_W      = 16;
    localparam int unsigned MCPT_CHANNELS   = 4;
    localparam int unsigned MCPT_PSC_W      = 16;
    localparam logic [15:0] MCPT_CNT_RST    = 16'h0000;
    localparam logic [15:0] MCPT_PSC_RST    = 16'h0000;
    localparam logic [7:0]  MCPT_DT_RST     = 8'h00;
    localparam int unsigned MCPT_SYNC_STAGES = 2;

    // Counting direction selection
    typedef enum logic [1:0] {
        MCPT_CNT_UP,
        MCPT_CNT_DOWN,
        MCPT_CNT_CENTER
    } mcpt_cnt_mode_t;

    // Per-channel function selection
    typedef enum logic [2:0] {
        MCPT_CH_OFF,
        MCPT_CH_CAPTURE,
        MCPT_CH_COMPARE,
        MCPT_CH_PWM,
        MCPT_CH_ONEPULSE
    } mcpt_ch_mode_t;

    // Slave trigger action
    typedef enum logic [1:0] {
        MCPT_SLV_NONE,
        MCPT_SLV_START,
        MCPT_SLV_RESET,
        MCPT_SLV_CLOCK
    } mcpt_slv_mode_t;
endpackage : mcpt_pkg
`default_nettype wire

/* hw/mcpt_timer.sv */
// Advanced motor control timer: prescaled 16-bit counter, four channels,
// complementary outputs with dead time, debug freeze, trigger link, DMA requests.
// Assumes capture and trigger inputs come from outside the clock domain.
`default_nettype none
module mcpt_timer
    import mcpt_pkg::*;
#(
    parameter int unsigned DT_W = 8
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Counter configuration
    input  wire logic                     enable_i,
    input  wire mcpt_cnt_mode_t           cnt_mode_i,
    input  wire logic [MCPT_PSC_W-1:0]    prescale_i,
    input  wire logic [MCPT_CNT_W-1:0]    reload_i,
    input  wire logic                     one_pulse_stop_i,
    // Channel configuration
    input  wire mcpt_ch_mode_t [3:0]      ch_mode_i,
    input  wire logic [3:0][15:0]         ch_compare_i,
    input  wire logic [3:0]               ch_out_en_i,
    input  wire logic [DT_W-1:0]          dead_time_i,
    // Capture inputs and captured values
    input  wire logic [3:0]               capture_in_i,
    output logic [3:0][15:0]              capture_val_o,
    // Debug
    input  wire logic                     debug_halt_i,
    input  wire logic                     debug_freeze_en_i,
    // Timer link
    input  wire logic                     trig_in_i,
    input  wire mcpt_slv_mode_t           slave_mode_i,
    output logic                          trig_out_o,
    // DMA
    input  wire logic                     dma_upd_en_i,
    input  wire logic [3:0]               dma_ch_en_i,
    output logic                          dma_req_o,
    // Status
    output logic [MCPT_CNT_W-1:0]         count_o,
    output logic                          dir_down_o,
    output logic                          running_o,
    // Gate outputs
    output logic [3:0]                    pwm_hi_o,
    output logic [3:0]                    pwm_lo_o
);
    // Refuse widths that the logic cannot serve
    if (MCPT_CNT_W != 16 || DT_W < 1 || DT_W > 16) begin : g_bad_width
        $error("mcpt_timer: unsupported width");
    end

    logic [MCPT_PSC_W-1:0] psc_cnt_reg;
    logic [MCPT_CNT_W-1:0] cnt_reg;
    logic                  down_reg;
    logic                  run_reg;
    logic                  op_done_reg;
    logic [3:0]            cap_s1_reg;
    logic [3:0]            cap_s2_reg;
    logic [3:0]            cap_d_reg;
    logic                  trg_s1_reg;
    logic                  trg_s2_reg;
    logic                  trg_d_reg;
    logic [3:0]            ref_reg;
    logic [3:0]            match_reg;
    logic                  freeze;
    logic                  trg_rise;
    logic                  tick;
    logic                  wrap;
    logic [3:0]            cap_rise;

    // Synchronise capture and trigger inputs; edges compare the second stage with its delayed copy
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_s1_reg <= '0;
            cap_s2_reg <= '0;
            cap_d_reg  <= '0;
            trg_s1_reg <= 1'b0;
            trg_s2_reg <= 1'b0;
            trg_d_reg  <= 1'b0;
        end else begin
            cap_s1_reg <= capture_in_i;
            cap_s2_reg <= cap_s1_reg;
            cap_d_reg  <= cap_s2_reg;
            trg_s1_reg <= trig_in_i;
            trg_s2_reg <= trg_s1_reg;
            trg_d_reg  <= trg_s2_reg;
        end
    end

    assign trg_rise = trg_s2_reg & ~trg_d_reg;
    assign cap_rise = cap_s2_reg & ~cap_d_reg;
    assign freeze   = debug_halt_i & debug_freeze_en_i;

    // Counter tick: prescaler expiry, or external clock in clock slave mode
    always_comb begin
        if (slave_mode_i == MCPT_SLV_CLOCK) begin
            tick = trg_rise;
        end else begin
            // At or above, so lowering the division mid-count cannot stall a full wrap
            tick = (psc_cnt_reg >= prescale_i);
        end
    end

    // Wrap point depends on counting mode
    always_comb begin
        case (cnt_mode_i)
            MCPT_CNT_UP:     wrap = (cnt_reg == reload_i);
            MCPT_CNT_DOWN:   wrap = (cnt_reg == MCPT_CNT_RST);
            MCPT_CNT_CENTER: wrap = down_reg ? (cnt_reg == 16'h0001) || (cnt_reg == MCPT_CNT_RST)
                                             : (cnt_reg == reload_i);
            default:         wrap = 1'b0;
        endcase
    end

    // One-pulse done flag: keeps the counter stopped until enable drops; in start slave mode a trigger restarts it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_done_reg <= 1'b0;
        end else if (!enable_i) begin
            op_done_reg <= 1'b0;
        end else if (run_reg && one_pulse_stop_i && tick && wrap && !freeze) begin
            op_done_reg <= 1'b1;
        end
    end

    // Run control: enable, start trigger, and one-pulse stop at update
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg <= 1'b0;
        end else if (!enable_i) begin
            run_reg <= 1'b0;
        end else if (slave_mode_i == MCPT_SLV_START && !run_reg) begin
            run_reg <= trg_rise;
        end else if (slave_mode_i != MCPT_SLV_START && !run_reg && !op_done_reg) begin
            run_reg <= 1'b1;
        end else if (run_reg && one_pulse_stop_i && tick && wrap && !freeze) begin
            run_reg <= 1'b0;
        end
    end

    // Prescaler divides by prescale_i + 1
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            psc_cnt_reg <= MCPT_PSC_RST;
        end else if (!run_reg || freeze || tick || (slave_mode_i == MCPT_SLV_RESET && trg_rise)) begin
            psc_cnt_reg <= freeze ? psc_cnt_reg : MCPT_PSC_RST;
        end else begin
            psc_cnt_reg <= psc_cnt_reg + 1'b1;
        end
    end

    // Main counter with reload on overflow or underflow
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= MCPT_CNT_RST;
            down_reg <= 1'b0;
        end else if (slave_mode_i == MCPT_SLV_RESET && trg_rise) begin
            cnt_reg  <= (cnt_mode_i == MCPT_CNT_DOWN) ? reload_i : MCPT_CNT_RST;
            down_reg <= (cnt_mode_i == MCPT_CNT_DOWN);
        end else if (run_reg && tick && !freeze) begin
            case (cnt_mode_i)
                MCPT_CNT_UP: begin
                    down_reg <= 1'b0;
                    cnt_reg  <= wrap ? MCPT_CNT_RST : cnt_reg + 1'b1;
                end
                MCPT_CNT_DOWN: begin
                    down_reg <= 1'b1;
                    cnt_reg  <= wrap ? reload_i : cnt_reg - 1'b1;
                end
                MCPT_CNT_CENTER: begin
                    if (wrap) begin
                        down_reg <= ~down_reg;
                    end
                    if (down_reg) begin
                        cnt_reg <= (cnt_reg == MCPT_CNT_RST) ? 16'h0001 : cnt_reg - 1'b1;
                    end else begin
                        cnt_reg <= (cnt_reg == reload_i) ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg;
                end
            endcase
        end
    end

    // Update event pulse, also driven out as the trigger to other timers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_out_o <= 1'b0;
        end else begin
            trig_out_o <= run_reg && tick && wrap && !freeze;
        end
    end

    // Per-channel capture, compare match and reference waveform
    for (genvar ch = 0; ch < MCPT_CHANNELS; ch++) begin : g_ch
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                capture_val_o[ch] <= MCPT_CNT_RST;
                match_reg[ch]     <= 1'b0;
                ref_reg[ch]       <= 1'b0;
            end else begin
                match_reg[ch] <= 1'b0;
                case (ch_mode_i[ch])
                    MCPT_CH_CAPTURE: begin
                        ref_reg[ch] <= 1'b0;
                        if (cap_rise[ch]) begin
                            capture_val_o[ch] <= cnt_reg;
                            match_reg[ch]     <= 1'b1;
                        end
                    end
                    MCPT_CH_COMPARE: begin
                        if (run_reg && tick && cnt_reg == ch_compare_i[ch]) begin
                            ref_reg[ch]   <= ~ref_reg[ch];
                            match_reg[ch] <= 1'b1;
                        end
                    end
                    MCPT_CH_PWM, MCPT_CH_ONEPULSE: begin
                        // Active while count below compare: 0 gives 0%, above reload gives 100%
                        ref_reg[ch]   <= run_reg && (cnt_reg < ch_compare_i[ch]);
                        match_reg[ch] <= run_reg && tick && (cnt_reg == ch_compare_i[ch]);
                    end
                    default: begin
                        ref_reg[ch] <= 1'b0;
                    end
                endcase
            end
        end

        // Complementary pair for this phase
        mcpt_deadtime #(
            .DT_W        (DT_W)
        ) u_dt (
            .clk_i       (clk_i),
            .rst_n_i     (rst_n_i),
            .enable_i    (ch_out_en_i[ch]),
            .force_off_i (freeze),
            .dead_time_i (dead_time_i),
            .ref_i       (ref_reg[ch]),
            .out_hi_o    (pwm_hi_o[ch]),
            .out_lo_o    (pwm_lo_o[ch])
        );
    end

    // DMA request on update or enabled channel event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_req_o <= 1'b0;
        end else begin
            dma_req_o <= (dma_upd_en_i && run_reg && tick && wrap && !freeze)
                         || |(dma_ch_en_i & match_reg);
        end
    end

    assign count_o    = cnt_reg;
    assign dir_down_o = down_reg;
    assign running_o  = run_reg;
endmodule : mcpt_timer
`default_nettype wire

/* test/mcpt_gate_model.sv */
// Far side of the timer: gate drivers watching each pair, and capture sources.
// Assumes pulse requests are one-cycle strobes on the timer clock.
`default_nettype none
module mcpt_gate_model (
    // Clock and requests
    input  wire logic       clk_i,
    input  wire logic [3:0] pulse_req_i,
    // Gate drives
    input  wire logic [3:0] gate_hi_i,
    input  wire logic [3:0] gate_lo_i,
    // Capture lines (pulled low) and shoot-through flag
    output logic [3:0]      capture_o,
    output logic            overlap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0][1:0] hold_reg = '0;
    initial overlap_o = 1'b0;
    // A pulse stands three clocks so the synchroniser surely sees it
    always @(posedge clk_i) begin
        for (int n = 0; n < 4; n++) begin
            if (pulse_req_i[n]) hold_reg[n] <= 2'h3;
            else if (hold_reg[n] != 2'h0) hold_reg[n] <= hold_reg[n] - 2'h1;
        end
        if ((gate_hi_i & gate_lo_i) != 4'h0) overlap_o <= 1'b1;
    end
    // Idle capture lines sit at their pull-down level
    always_comb begin
        for (int n = 0; n < 4; n++) capture_o[n] = (hold_reg[n] != 2'h0);
    end
endmodule : mcpt_gate_model
`default_nettype wire

/* test/mcpt_monitor.sv */
// Checker for the motor control PWM timer, watching its top ports only.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none
module mcpt_monitor
    import mcpt_pkg::*;
(
    // Clock, reset, configuration
    input wire logic           clk_i,
    input wire logic           rst_n_i,
    input wire logic           enable_i,
    input wire mcpt_cnt_mode_t cnt_mode_i,
    input wire logic [15:0]    prescale_i,
    input wire logic [15:0]    reload_i,
    input wire logic [3:0]     ch_out_en_i,
    input wire logic           debug_halt_i,
    input wire logic           debug_freeze_en_i,
    input wire mcpt_slv_mode_t slave_mode_i,
    input wire logic           dma_upd_en_i,
    // Outputs
    input wire logic           trig_out_o,
    input wire logic           dma_req_o,
    input wire logic [15:0]    count_o,
    input wire logic           running_o,
    input wire logic [3:0]     pwm_hi_o,
    input wire logic [3:0]     pwm_lo_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Freeze request and plain up counting at any prescale
    wire frz = debug_halt_i && debug_freeze_en_i;
    wire up1 = running_o && enable_i && !frz && cnt_mode_i == MCPT_CNT_UP && slave_mode_i == MCPT_SLV_NONE;
    no_overlap_a: assert property ((pwm_hi_o & pwm_lo_o) == 4'h0) else $error("pair both on");
    freeze_gates_a: assert property (frz |=> {pwm_hi_o, pwm_lo_o} == 8'h00) else $error("gate on in freeze");
    freeze_count_a: assert property (frz |=> $stable(count_o)) else $error("count moved in freeze");
    trig_pulse_a: assert property (trig_out_o && reload_i > 16'h0002 |=> !trig_out_o) else $error("update pulse too long");
    gate_off_a: assert property ((ch_out_en_i == 4'h0)[*2] |-> (pwm_hi_o | pwm_lo_o) == 4'h0) else $error("gate on");
    up_step_a: assert property (up1 && prescale_i == 16'h0000 && $past(prescale_i) == 16'h0000 && count_o < reload_i
        |=> count_o == $past(count_o) + 16'h0001) else $error("bad up step");
    wrap_trig_a: assert property (up1 && prescale_i == 16'h0000 && count_o == reload_i && reload_i != 16'h0000
        |-> ##[1:2] trig_out_o) else $error("no update at wrap");
    dma_upd_a: assert property (dma_upd_en_i && $past(dma_upd_en_i) && trig_out_o |-> dma_req_o) else $error("no dma");
    // Main scenarios reached
    cover property (trig_out_o);
    cover property (frz ##1 frz);
    cover property (dma_req_o);
endmodule : mcpt_monitor
bind mcpt_timer mcpt_monitor mcpt_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .cnt_mode_i(cnt_mode_i), .prescale_i(prescale_i), .reload_i(reload_i), .ch_out_en_i(ch_out_en_i),
    .debug_halt_i(debug_halt_i), .debug_freeze_en_i(debug_freeze_en_i), .slave_mode_i(slave_mode_i),
    .dma_upd_en_i(dma_upd_en_i), .trig_out_o(trig_out_o), .dma_req_o(dma_req_o), .count_o(count_o),
    .running_o(running_o), .pwm_hi_o(pwm_hi_o), .pwm_lo_o(pwm_lo_o));
`default_nettype wire

/* test/tb_top.sv */
// Testbench for the motor control PWM timer: one self-checking task per scenario.
// Assumes the gate model and the bound checker are compiled first.
`default_nettype none
module tb_top;
    import mcpt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
        $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
    logic clk_i = 1'b0, rst_n_i = 1'b0, enable = 1'b0, ops = 1'b0, halt = 1'b0, frz_en = 1'b0, trig_in = 1'b0;
    logic dma_upd = 1'b0, trig_out, dma_req, dir_down, running, overlap;
    mcpt_cnt_mode_t cnt_mode = MCPT_CNT_UP;
    mcpt_slv_mode_t slave = MCPT_SLV_NONE;
    mcpt_ch_mode_t [3:0] ch_mode;
    logic [15:0] prescale = 16'h0000, reload = 16'h0003, count;
    logic [3:0][15:0] cmp = '0, cap_val;
    logic [3:0] out_en = 4'h0, dma_ch = 4'h0, cap_in, pulse_req = 4'h0, hi, lo;
    logic [7:0] dead = 8'h00;
    int bad_count = 0, n_tests = 0;
    // Device and far-side model
    mcpt_timer mcpt_timer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable), .cnt_mode_i(cnt_mode),
        .prescale_i(prescale), .reload_i(reload), .one_pulse_stop_i(ops), .ch_mode_i(ch_mode), .ch_compare_i(cmp),
        .ch_out_en_i(out_en), .dead_time_i(dead), .capture_in_i(cap_in), .capture_val_o(cap_val),
        .debug_halt_i(halt), .debug_freeze_en_i(frz_en), .trig_in_i(trig_in), .slave_mode_i(slave),
        .trig_out_o(trig_out), .dma_upd_en_i(dma_upd), .dma_ch_en_i(dma_ch), .dma_req_o(dma_req), .count_o(count),
        .dir_down_o(dir_down), .running_o(running), .pwm_hi_o(hi), .pwm_lo_o(lo));
    mcpt_gate_model mcpt_gate_model_i (.clk_i(clk_i), .pulse_req_i(pulse_req), .gate_hi_i(hi), .gate_lo_i(lo),
        .capture_o(cap_in), .overlap_o(overlap));
    // 40 MHz clock
    initial forever #12.5 clk_i = ~clk_i;
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // Bounded wait for the update pulse; c counts the cycles waited
    task automatic wait_trig(output int c);
        c = 0;
        while (trig_out !== 1'b1) begin
            if (c == 2000) begin
                bad_count++;
                conclude();
            end
            tick(1);
            c++;
        end
    endtask : wait_trig
    // Update spacing for up and down counting at two prescale factors
    task automatic t_period();
        int c;
        logic [1:0] seen;
        enable = 1'b1;
        dma_upd = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cnt_mode = i[0] ? MCPT_CNT_DOWN : MCPT_CNT_UP;
            prescale = i[1] ? 16'h0002 : 16'h0000;
            repeat (2) begin
                wait_trig(c);
                tick(1);
            end
            wait_trig(c);
            `CHK("dma on update", 1'b1, dma_req)
            `CHK("update spacing", i[1] ? 11 : 3, c)
            tick(1);
        end
        cnt_mode = MCPT_CNT_CENTER;
        prescale = 16'h0000;
        seen = 2'b00;
        repeat (40) begin
            tick(1);
            seen |= {dir_down, ~dir_down};
        end
        `CHK("centre turns", 2'b11, seen)
        $display("done: period");
    endtask : t_period
    // Four phases at duties 0, 50, 100 and 25 percent with one cycle dead time
    task automatic t_pwm();
        int h[4] = '{0, 0, 0, 0};
        int l[4] = '{0, 0, 0, 0};
        int eh[4] = '{0, 24, 64, 8};
        int el[4] = '{64, 24, 0, 40};
        cnt_mode = MCPT_CNT_UP;
        reload = 16'h0007;
        dead = 8'h01;
        out_en = 4'hf;
        cmp = {16'h0002, 16'h0008, 16'h0004, 16'h0000};
        for (int n = 0; n < 4; n++) ch_mode[n] = MCPT_CH_PWM;
        tick(32);
        repeat (64) begin
            tick(1);
            for (int n = 0; n < 4; n++) h[n] += (hi[n] === 1'b1);
            for (int n = 0; n < 4; n++) l[n] += (lo[n] === 1'b1);
        end
        for (int n = 0; n < 4; n++) `CHK("high gate time", eh[n], h[n])
        for (int n = 0; n < 4; n++) `CHK("low gate time", el[n], l[n])
        `CHK("pair overlap", 1'b0, overlap)
        $display("done: pwm");
    endtask : t_pwm
    // Halt alone keeps running; halt with freeze stops count and gates
    task automatic t_freeze();
        logic [15:0] held;
        logic [3:0] act;
        halt = 1'b1;
        act = 4'h0;
        repeat (16) begin
            tick(1);
            act |= hi | lo;
        end
        `CHK("halt only", 4'hf, act)
        frz_en = 1'b1;
        tick(2);
        held = count;
        tick(5);
        `CHK("frozen count", held, count)
        `CHK("frozen gates", 8'h00, {hi, lo})
        halt = 1'b0;
        out_en = 4'h0;
        tick(3);
        `CHK("gates off", 8'h00, {hi, lo})
        $display("done: freeze");
    endtask : t_freeze
    // Two captures eleven cycles apart
    task automatic t_capture();
        for (int n = 0; n < 4; n++) ch_mode[n] = MCPT_CH_CAPTURE;
        reload = 16'hffff;
        pulse_req = 4'h1;
        tick(1);
        pulse_req = 4'h0;
        tick(10);
        pulse_req = 4'h2;
        tick(1);
        pulse_req = 4'h0;
        tick(10);
        `CHK("capture spacing", 16'h000b, cap_val[1] - cap_val[0])
        $display("done: capture");
    endtask : t_capture
    // Mid-run reset, then start on a link trigger
    task automatic t_link();
        rst_n_i = 1'b0;
        tick(1);
        rst_n_i = 1'b1;
        slave = MCPT_SLV_START;
        tick(10);
        `CHK("idle before trigger", 1'b0, running)
        trig_in = 1'b1;
        tick(2);
        trig_in = 1'b0;
        tick(6);
        `CHK("run after trigger", 1'b1, running)
        $display("done: link");
    endtask : t_link
    // Link trigger resets the counter, then clocks it in external clock mode
    task automatic t_slave();
        logic [15:0] held;
        slave = MCPT_SLV_RESET;
        trig_in = 1'b1;
        tick(3);
        `CHK("reset by link", 16'h0000, count)
        trig_in = 1'b0;
        slave = MCPT_SLV_CLOCK;
        tick(1);
        held = count;
        repeat (3) begin
            trig_in = 1'b1;
            tick(2);
            trig_in = 1'b0;
            tick(2);
        end
        tick(2);
        `CHK("link clock steps", held + 16'h0003, count)
        $display("done: slave");
    endtask : t_slave
    // One-pulse: counter stops at the update and stays stopped until enable drops
    task automatic t_onepulse();
        int c;
        slave = MCPT_SLV_NONE;
        reload = 16'h0007;
        cmp[0] = 16'h0007;
        ch_mode[0] = MCPT_CH_ONEPULSE;
        out_en = 4'h1;
        ops = 1'b1;
        wait_trig(c);
        tick(4);
        `CHK("one pulse stop", 1'b0, running)
        `CHK("one pulse gates", 2'b01, {hi[0], lo[0]})
        enable = 1'b0;
        ops = 1'b0;
        tick(1);
        enable = 1'b1;
        tick(2);
        `CHK("one pulse rearm", 1'b1, running)
        $display("done: one pulse");
    endtask : t_onepulse
    // Compare toggles its reference at each match; each match raises a DMA request
    task automatic t_compare();
        int d = 0;
        int h = 0;
        ch_mode[1] = MCPT_CH_COMPARE;
        cmp[1] = 16'h0002;
        out_en = 4'h2;
        dma_upd = 1'b0;
        dma_ch = 4'h2;
        tick(20);
        repeat (32) begin
            tick(1);
            d += (dma_req === 1'b1);
            h += (hi[1] === 1'b1);
        end
        `CHK("compare dma count", 4, d)
        `CHK("compare high time", 14, h)
        $display("done: compare");
    endtask : t_compare
    // Main sequence
    initial begin
        for (int n = 0; n < 4; n++) ch_mode[n] = MCPT_CH_OFF;
        tick(3);
        rst_n_i = 1'b1;
        t_period();
        t_pwm();
        t_freeze();
        t_capture();
        t_link();
        t_slave();
        t_onepulse();
        t_compare();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
